// ==== sbc_spi_response_frame_logic.v ====
// Response-frame logic of the base chip's serial slave, with an AHB-Lite status port.
// Assumes chipMode and the cause/event inputs come from logic on clk; spi pins are async.
//
// Notes on behaviour
// - Normal frame returns data chosen last frame
// - First normal-mode frame reports previous chip mode
// - First frame after sleep or fail-safe selects wake or fallback register
// - Failure restart with odd config reports restart, selects fallback
// - Host restart or init selects chip configuration
// - First-frame readout leaves flags set
// - Read-only is a mode selection field value
// - Read-only clears selected flags, not live state
// - Read-only writes nothing, keeps mode
// - Read-only still kicks the watchdog
// - Read-only returns selected register same frame
// - Other commands answer in following frame
// - Restart cause clears on read or return
// - Fallback cause clears when output switched off
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_resp_map.vh"
module sbc_spi_response_frame_logic (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata_ff,
  output reg         hreadyout_ff,
  output reg         hresp_ff,
  input  wire        spiClk,
  input  wire        chipSelectLow,
  input  wire        serialDataInput,
  output reg         serialDataOutput_ff,
  output reg         serialDataOutputEn_ff,
  input  wire [2:0]  chipMode,
  input  wire        restartByHost,
  input  wire        hwConfigOdd,
  input  wire [9:0]  wakeEvents,
  input  wire [9:0]  wakeLive,
  input  wire        restartCauseSet,
  input  wire [1:0]  restartCauseIn,
  input  wire        fallbackCauseSet,
  input  wire [2:0]  fallbackCauseIn,
  output reg  [2:0]  modeReq_ff,
  output reg         modeReqStrobe_ff,
  output reg         regWrStrobe_ff,
  output reg  [2:0]  regWrSel_ff,
  output reg  [9:0]  regWrData_ff,
  output reg         watchdogKick_ff,
  output reg         irq_ff
);

  // Register view presented on the output for a given select
  function [9:0] regView;
    input [2:0] sel;
    input [9:0] wakeFlags;
    input [9:0] live;
    input [1:0] restartC;
    input [2:0] fallbackC;
    input [9:0] bankWord;
    begin
      case (sel)
        `SEL_WAKE:     regView = wakeFlags | live;
        `SEL_FALLBACK: regView = {5'h00, fallbackC, restartC};
        default:       regView = bankWord;
      endcase
    end
  endfunction

  // Synchronisers; the first stage feeds only the second
  reg        sclkS1_ff, sclkS2_ff, sclkS3_ff;
  reg        csS1_ff, csS2_ff, csS3_ff;
  reg        sdiS1_ff, sdiS2_ff;
  wire       sclkRise = sclkS2_ff & ~sclkS3_ff;
  wire       sclkFall = ~sclkS2_ff & sclkS3_ff;
  wire       csFall   = ~csS2_ff & csS3_ff;
  wire       csRise   = csS2_ff & ~csS3_ff;

  reg  [4:0]  bitCnt_ff;
  reg  [15:0] inWord_ff;
  reg  [15:0] outWord_ff;
  reg         roArmed_ff;
  reg  [2:0]  nextSel_ff;
  reg  [9:0]  bank_ff [0:7];
  reg  [9:0]  wakeFlags_ff;
  reg  [1:0]  restartCause_ff;
  reg  [2:0]  fallbackCause_ff;
  reg  [2:0]  chipModeD_ff;
  reg         firstPending_ff;
  reg  [2:0]  firstMode_ff;
  reg  [2:0]  firstSel_ff;
  reg         clrPulse_ff;
  reg  [2:0]  clrSel_ff;
  reg  [2:0]  lastMode_ff;
  reg  [2:0]  lastSel_ff;
  reg  [`EV_WIDTH-1:0] status_ff;
  reg  [`EV_WIDTH-1:0] enable_ff;
  reg  [`EV_WIDTH-1:0] evPulse_ff;
  reg         dpWrite_ff;
  reg  [3:0]  dpAddr_ff;
  integer     i;

  wire [2:0] rxMode = inWord_ff[`MODE_LO:`MODE_HI];
  wire [2:0] rxSel  = inWord_ff[`SEL_HI:`SEL_LO];
  wire       rxRO   = (rxMode == `MODE_READONLY);
  wire       enterNormal = (chipMode == `MODE_NORMAL) && (chipModeD_ff != `MODE_NORMAL);
  wire       fromSleepFs = (chipModeD_ff == `MODE_SLEEP) || (chipModeD_ff == `MODE_FAILSAFE);
  wire [9:0] viewNext = regView(nextSel_ff, wakeFlags_ff, wakeLive, restartCause_ff,
                                fallbackCause_ff, bank_ff[nextSel_ff]);
  wire [9:0] viewFirst = regView(firstSel_ff, wakeFlags_ff, wakeLive, restartCause_ff,
                                 fallbackCause_ff, bank_ff[firstSel_ff]);
  wire [9:0] viewRx = regView(rxSel, wakeFlags_ff, wakeLive, restartCause_ff,
                              fallbackCause_ff, bank_ff[rxSel]);
  wire       fbOff = regWrStrobe_ff && (regWrSel_ff == `SEL_CHIPCFG) &&
                     regWrData_ff[`FB_OFF_BIT];

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclkS1_ff <= 1'b0;
      sclkS2_ff <= 1'b0;
      sclkS3_ff <= 1'b0;
      csS1_ff   <= 1'b1;
      csS2_ff   <= 1'b1;
      csS3_ff   <= 1'b1;
      sdiS1_ff  <= 1'b0;
      sdiS2_ff  <= 1'b0;
    end else begin
      sclkS1_ff <= spiClk;
      sclkS2_ff <= sclkS1_ff;
      sclkS3_ff <= sclkS2_ff;
      csS1_ff   <= chipSelectLow;
      csS2_ff   <= csS1_ff;
      csS3_ff   <= csS2_ff;
      sdiS1_ff  <= serialDataInput;
      sdiS2_ff  <= sdiS1_ff;
    end
  end

  // Mode entry tracking for the first frame in normal mode
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chipModeD_ff    <= `MODE_INIT;
      firstPending_ff <= 1'b0;
      firstMode_ff    <= `MODE_INIT;
      firstSel_ff     <= `SEL_CHIPCFG;
    end else begin
      chipModeD_ff <= chipMode;
      if (enterNormal) begin
        firstPending_ff <= 1'b1;
        firstMode_ff    <= chipModeD_ff;
        case (chipModeD_ff)
          `MODE_SLEEP:    firstSel_ff <= `SEL_WAKE;
          `MODE_FAILSAFE: firstSel_ff <= `SEL_FALLBACK;
          `MODE_RESTART: begin
            if (!restartByHost && hwConfigOdd)
              firstSel_ff <= `SEL_FALLBACK;
            else
              firstSel_ff <= `SEL_CHIPCFG;
          end
          default:        firstSel_ff <= `SEL_CHIPCFG;
        endcase
      end else if (csFall) begin
        firstPending_ff <= 1'b0;
      end
    end
  end

  // Serial frame engine
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bitCnt_ff             <= 5'h00;
      inWord_ff             <= `ZERO_FRAME;
      outWord_ff            <= `ZERO_FRAME;
      roArmed_ff            <= 1'b0;
      nextSel_ff            <= `SEL_CHIPCFG;
      serialDataOutput_ff   <= 1'b0;
      serialDataOutputEn_ff <= 1'b0;
      clrPulse_ff           <= 1'b0;
      clrSel_ff             <= `SEL_CHIPCFG;
      modeReq_ff            <= `MODE_INIT;
      modeReqStrobe_ff      <= 1'b0;
      regWrStrobe_ff        <= 1'b0;
      regWrSel_ff           <= `SEL_CHIPCFG;
      regWrData_ff          <= `ZERO_DATA;
      watchdogKick_ff       <= 1'b0;
      lastMode_ff           <= `MODE_INIT;
      lastSel_ff            <= `SEL_CHIPCFG;
      evPulse_ff            <= `ZERO_EV;
    end else begin
      clrPulse_ff      <= 1'b0;
      modeReqStrobe_ff <= 1'b0;
      regWrStrobe_ff   <= 1'b0;
      watchdogKick_ff  <= 1'b0;
      evPulse_ff       <= `ZERO_EV;
      if (csFall) begin
        bitCnt_ff             <= 5'h00;
        roArmed_ff            <= 1'b1;
        serialDataOutputEn_ff <= 1'b1;
        if (firstPending_ff) begin
          // First readout leaves the flags alone
          outWord_ff          <= {viewFirst, firstSel_ff, firstMode_ff};
          serialDataOutput_ff <= firstMode_ff[0];
        end else begin
          outWord_ff          <= {viewNext, nextSel_ff, chipMode};
          serialDataOutput_ff <= chipMode[0];
          clrPulse_ff         <= 1'b1;
          clrSel_ff           <= nextSel_ff;
        end
      end else if (csRise) begin
        serialDataOutputEn_ff <= 1'b0;
        roArmed_ff            <= 1'b0;
        if (bitCnt_ff == `FRAME_BITS) begin
          evPulse_ff[`EV_FRAME] <= 1'b1;
          watchdogKick_ff       <= 1'b1;
          lastMode_ff           <= rxMode;
          lastSel_ff            <= rxSel;
          nextSel_ff            <= rxSel;
          if (rxRO) begin
            evPulse_ff[`EV_READONLY] <= 1'b1;
          end else begin
            modeReq_ff       <= rxMode;
            modeReqStrobe_ff <= 1'b1;
            regWrStrobe_ff   <= 1'b1;
            regWrSel_ff      <= rxSel;
            regWrData_ff     <= inWord_ff[`DATA_HI:`DATA_LO];
          end
        end else begin
          // Short or long frames write nothing; a read-only clear made after six bits still stands
          evPulse_ff[`EV_BADLEN] <= 1'b1;
        end
      end else if (!csS2_ff) begin
        if (sclkRise) begin
          if (bitCnt_ff != `FRAME_BITS) begin
            inWord_ff[bitCnt_ff[3:0]] <= sdiS2_ff;
            bitCnt_ff                 <= bitCnt_ff + 5'h01;
          end else begin
            bitCnt_ff <= bitCnt_ff + 5'h01;
          end
        end else if (sclkFall) begin
          if (bitCnt_ff < `FRAME_BITS)
            serialDataOutput_ff <= outWord_ff[bitCnt_ff[3:0]];
        end
        // Select is known after six bits, well before the next falling edge
        if (roArmed_ff && bitCnt_ff == `SEL_DONE_BITS && !sclkRise) begin
          roArmed_ff <= 1'b0;
          if (rxRO) begin
            outWord_ff[`DATA_HI:`DATA_LO] <= viewRx;
            clrPulse_ff                   <= 1'b1;
            clrSel_ff                     <= rxSel;
          end
        end
      end
    end
  end

  // Flags and causes; a new event beats a clear in the same cycle
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wakeFlags_ff     <= `ZERO_DATA;
      restartCause_ff  <= 2'h0;
      fallbackCause_ff <= 3'h0;
      for (i = 0; i < 8; i = i + 1)
        bank_ff[i] <= `ZERO_DATA;
    end else begin
      if (clrPulse_ff && clrSel_ff == `SEL_WAKE)
        wakeFlags_ff <= wakeEvents;
      else
        wakeFlags_ff <= wakeFlags_ff | wakeEvents;
      if (restartCauseSet)
        restartCause_ff <= restartCauseIn;
      else if ((clrPulse_ff && clrSel_ff == `SEL_FALLBACK) || (enterNormal && fromSleepFs))
        restartCause_ff <= 2'h0;
      if (fallbackCauseSet)
        fallbackCause_ff <= fallbackCauseIn;
      else if (fbOff)
        fallbackCause_ff <= 3'h0;
      if (regWrStrobe_ff)
        bank_ff[regWrSel_ff] <= regWrData_ff;
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  wire addrPhase = hsel && hready && htrans[1];
  wire [31:0] infoWord = {16'h0000, 3'h0, firstPending_ff, 1'b0, firstMode_ff,
                          1'b0, lastMode_ff, 1'b0, lastSel_ff};

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata_ff    <= `ZERO_WORD;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
      dpWrite_ff   <= 1'b0;
      dpAddr_ff    <= 4'h0;
      status_ff    <= `ZERO_EV;
      enable_ff    <= `ZERO_EV;
      irq_ff       <= 1'b0;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
      dpWrite_ff   <= addrPhase && hwrite;
      dpAddr_ff    <= haddr[3:0];
      if (addrPhase && !hwrite) begin
        case (haddr[3:0])
          `ADDR_STATUS: hrdata_ff <= {29'h00000000, status_ff};
          `ADDR_ENABLE: hrdata_ff <= {29'h00000000, enable_ff};
          `ADDR_INFO:   hrdata_ff <= infoWord;
          default:      hrdata_ff <= `ZERO_WORD;
        endcase
      end
      if (dpWrite_ff && dpAddr_ff == `ADDR_CLEAR)
        status_ff <= (status_ff & ~hwdata[`EV_WIDTH-1:0]) | evPulse_ff;
      else
        status_ff <= status_ff | evPulse_ff;
      if (dpWrite_ff && dpAddr_ff == `ADDR_ENABLE)
        enable_ff <= hwdata[`EV_WIDTH-1:0];
      irq_ff <= |(status_ff & enable_ff);
    end
  end

endmodule
`default_nettype wire

// ==== sbc_resp_map.vh ====
// Constants for the response-frame logic of the base chip's serial slave.
// Assumes a 16-bit frame, least significant bit first, and a 32-bit AHB-Lite bus.
`ifndef SBC_RESP_MAP_VH
`define SBC_RESP_MAP_VH
// Frame layout
`define FRAME_BITS      5'h10
`define FRAME_LAST      4'hF
`define SEL_DONE_BITS   5'h06
`define MODE_LO         2
`define MODE_HI         0
`define SEL_HI          5
`define SEL_LO          3
`define DATA_HI         15
`define DATA_LO         6
// Mode selection field codes
`define MODE_INIT       3'h0
`define MODE_NORMAL     3'h1
`define MODE_SLEEP      3'h2
`define MODE_RESTART    3'h3
`define MODE_FAILSAFE   3'h4
`define MODE_READONLY   3'h7
// Configuration select codes
`define SEL_CHIPCFG     3'h0
`define SEL_WAKE        3'h1
`define SEL_FALLBACK    3'h7
// Chip configuration data bit that switches the fallback output off
`define FB_OFF_BIT      0
// Register offsets (byte addresses)
`define ADDR_STATUS     4'h0
`define ADDR_CLEAR      4'h4
`define ADDR_ENABLE     4'h8
`define ADDR_INFO       4'hC
// Event bits
`define EV_FRAME        0
`define EV_READONLY     1
`define EV_BADLEN       2
`define EV_WIDTH        3
// Reset values
`define ZERO_EV         3'h0
`define ZERO_WORD       32'h00000000
`define ZERO_DATA       10'h000
`define ZERO_FRAME      16'h0000
`endif

// ==== sbc_resp_monitor.sv ====
// Checker for the response-frame block, watching its ports only.
// Assumes the bind below; chip select is held high long between frames.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_resp_map.vh"
module sbc_resp_monitor (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       chipSelectLow,
  input wire logic       serialDataOutputEn_ff,
  input wire logic       hreadyout_ff,
  input wire logic       hresp_ff,
  input wire logic [2:0] modeReq_ff,
  input wire logic       modeReqStrobe_ff,
  input wire logic       regWrStrobe_ff,
  input wire logic       watchdogKick_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Eight cycles covers the select synchroniser lag
  sequence selIdle;
    chipSelectLow [*8];
  endsequence
  sequence selBusy;
    !chipSelectLow [*8];
  endsequence
  bus_ready_a: assert property (hreadyout_ff) else $error("hready low");
  bus_okay_a: assert property (!hresp_ff) else $error("error response");
  idle_release_a: assert property (selIdle |-> !serialDataOutputEn_ff)
    else $error("output driven outside frame");
  frame_drive_a: assert property (selBusy |-> serialDataOutputEn_ff)
    else $error("output not driven in frame");
  kick_pulse_a: assert property (watchdogKick_ff |=> !watchdogKick_ff)
    else $error("kick longer than one cycle");
  kick_after_frame_a: assert property (watchdogKick_ff |-> chipSelectLow && $past(chipSelectLow))
    else $error("kick inside frame");
  write_pulse_a: assert property (regWrStrobe_ff |=> !regWrStrobe_ff)
    else $error("write strobe too long");
  write_after_frame_a: assert property (regWrStrobe_ff |-> chipSelectLow)
    else $error("write inside frame");
  mode_pulse_a: assert property (modeReqStrobe_ff |=> !modeReqStrobe_ff)
    else $error("mode strobe too long");
  mode_keep_a: assert property (modeReqStrobe_ff |-> modeReq_ff != `MODE_READONLY)
    else $error("read-only taken as mode change");
endmodule
bind sbc_spi_response_frame_logic sbc_resp_monitor mon (.clk, .sys_rst, .chipSelectLow,
  .serialDataOutputEn_ff, .hreadyout_ff, .hresp_ff, .modeReq_ff, .modeReqStrobe_ff,
  .regWrStrobe_ff, .watchdogKick_ff);
`default_nettype wire

// ==== spi_host_model.sv ====
// Host model: serial master framing 16-bit words, least significant bit first.
// Assumes the bench calls xfer; link clock period 320 ns, eight clk periods.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output var logic spiClk,
  output var logic chipSelectLow,
  output var logic serialDataInput,
  input wire logic serialDataOutput,
  input wire logic serialDataOutputEn
);
  initial begin
    spiClk = 1'b0;
    chipSelectLow = 1'b1;
    serialDataInput = 1'b0;
  end
  // Released output reads as the inverse: no pull on that pin
  task automatic shift(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    // Off the clk edges, so the synchronisers never race the link
    #7 chipSelectLow = 1'b0;
    #320;
    for (int i = 0; i < n; i++) begin
      serialDataInput = tx[i];
      #160 rx[i] = serialDataOutputEn ? serialDataOutput : ~serialDataOutput;
      spiClk = 1'b1;
      #160 spiClk = 1'b0;
    end
    #160 chipSelectLow = 1'b1;
    serialDataInput = 1'b0;
    // Gap lets frame-end pulses land; keeps the link phase fixed to clk
    #9993;
  endtask
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    shift(tx, 16, rx);
  endtask
  task automatic cutFrame(input int n);
    logic [15:0] rx;
    shift(16'h0000, n, rx);
  endtask
endmodule
`default_nettype wire

// ==== sbc_spi_response_frame_logic_test.sv ====
// Bench for the response-frame block: host frames on the link, registers on AHB-Lite.
// Assumes the block, its header, the host model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_resp_map.vh"
module sbc_spi_response_frame_logic_test;
  logic        clk, sys_rst, hsel, hwrite, spiClk, chipSelectLow, serialDataInput;
  logic        restartByHost, hwConfigOdd, restartCauseSet, fallbackCauseSet;
  logic        hreadyout_ff, hresp_ff, serialDataOutput_ff, serialDataOutputEn_ff;
  logic        modeReqStrobe_ff, regWrStrobe_ff, watchdogKick_ff, irq_ff;
  logic [31:0] haddr, hwdata, hrdata_ff;
  logic [1:0]  htrans, restartCauseIn;
  logic [2:0]  hsize, chipMode, fallbackCauseIn, modeReq_ff, regWrSel_ff;
  logic [9:0]  wakeEvents, wakeLive, regWrData_ff;
  int          bad_count, n_checks, kicks, writes;
  sbc_spi_response_frame_logic DUT (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout_ff),
    .hrdata_ff(hrdata_ff), .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff),
    .spiClk(spiClk), .chipSelectLow(chipSelectLow), .serialDataInput(serialDataInput),
    .serialDataOutput_ff(serialDataOutput_ff), .serialDataOutputEn_ff(serialDataOutputEn_ff),
    .chipMode(chipMode), .restartByHost(restartByHost), .hwConfigOdd(hwConfigOdd),
    .wakeEvents(wakeEvents), .wakeLive(wakeLive), .restartCauseSet(restartCauseSet),
    .restartCauseIn(restartCauseIn), .fallbackCauseSet(fallbackCauseSet),
    .fallbackCauseIn(fallbackCauseIn), .modeReq_ff(modeReq_ff),
    .modeReqStrobe_ff(modeReqStrobe_ff), .regWrStrobe_ff(regWrStrobe_ff),
    .regWrSel_ff(regWrSel_ff), .regWrData_ff(regWrData_ff),
    .watchdogKick_ff(watchdogKick_ff), .irq_ff(irq_ff)
  );
  spi_host_model host (.spiClk(spiClk), .chipSelectLow(chipSelectLow),
    .serialDataInput(serialDataInput), .serialDataOutput(serialDataOutput_ff),
    .serialDataOutputEn(serialDataOutputEn_ff));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    kicks += watchdogKick_ff;
    writes += regWrStrobe_ff + modeReqStrobe_ff;
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic waitReady;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout_ff !== 1'b1 && k < 50);
    if (k >= 50) begin
      bad_count++;
      end_of_test;
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    waitReady;
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady;
    rd = hrdata_ff;
  endtask
  task automatic firstFrames;
    logic [2:0] pm [5] = '{`MODE_SLEEP, `MODE_FAILSAFE, `MODE_RESTART, `MODE_RESTART, `MODE_INIT};
    logic [2:0] es [5] = '{`SEL_WAKE, `SEL_FALLBACK, `SEL_FALLBACK, `SEL_CHIPCFG, `SEL_CHIPCFG};
    logic [15:0] rx;
    for (int i = 0; i < 5; i++) begin
      chipMode <= pm[i];
      hwConfigOdd <= (i == 2);
      restartByHost <= (i == 3);
      repeat (4) @(posedge clk);
      chipMode <= `MODE_NORMAL;
      repeat (4) @(posedge clk);
      host.xfer({10'h000, `SEL_CHIPCFG, `MODE_NORMAL}, rx);
      chk("first frame", rx[5:0], {es[i], pm[i]});
      @(posedge clk);
    end
  endtask
  task automatic wakeRead;
    logic [15:0] rx;
    wakeLive <= 10'h020;
    chipMode <= `MODE_SLEEP;
    wakeEvents <= 10'h008;
    @(posedge clk);
    wakeEvents <= 10'h000;
    repeat (3) @(posedge clk);
    chipMode <= `MODE_NORMAL;
    repeat (4) @(posedge clk);
    host.xfer({10'h000, `SEL_WAKE, `MODE_NORMAL}, rx);
    chk("wake first", rx, {10'h028, `SEL_WAKE, `MODE_SLEEP});
    host.xfer({10'h000, `SEL_CHIPCFG, `MODE_NORMAL}, rx);
    chk("wake deferred", rx, {10'h028, `SEL_WAKE, `MODE_NORMAL});
    @(posedge clk);
    wakeEvents <= 10'h004;
    @(posedge clk);
    wakeEvents <= 10'h000;
    @(posedge clk);
    // Select field is already out when read-only is decoded
    host.xfer({10'h000, `SEL_WAKE, `MODE_READONLY}, rx);
    chk("wake read-only", rx[15:3], {10'h024, `SEL_CHIPCFG});
    host.xfer({10'h000, `SEL_WAKE, `MODE_READONLY}, rx);
    chk("wake cleared", rx[15:3], {10'h020, `SEL_WAKE});
    @(posedge clk);
  endtask
  task automatic readOnly;
    logic [15:0] rx;
    logic [31:0] rd;
    int k0, w0;
    ahb(0, 32'(`ADDR_ENABLE), 0, rd);
    chk("enable reset", rd, 0);
    ahb(1, 32'(`ADDR_CLEAR), 32'h7, rd);
    ahb(1, 32'(`ADDR_ENABLE), 32'h2, rd);
    k0 = kicks;
    w0 = writes;
    host.xfer({10'h3FF, `SEL_CHIPCFG, `MODE_READONLY}, rx);
    @(posedge clk);
    chk("kick", kicks - k0, 1);
    chk("no write", writes - w0, 0);
    chk("irq", irq_ff, 1);
    ahb(0, 32'(`ADDR_STATUS), 0, rd);
    chk("status", rd, 32'h3);
    ahb(0, 32'(`ADDR_INFO), 0, rd);
    chk("info", rd, 32'h00000270);
    ahb(1, 32'(`ADDR_CLEAR), 32'h2, rd);
    ahb(1, 32'(`ADDR_ENABLE), 32'h0, rd);
    host.xfer({10'h000, `SEL_CHIPCFG, `MODE_READONLY}, rx);
    @(posedge clk);
    chk("masked", irq_ff, 0);
    ahb(0, 32'(`ADDR_CLEAR), 0, rd);
    chk("unmapped", rd, 0);
    k0 = kicks;
    w0 = writes;
    ahb(1, 32'(`ADDR_CLEAR), 32'h7, rd);
    host.cutFrame(8);
    @(posedge clk);
    chk("cut kick", kicks - k0, 0);
    chk("cut write", writes - w0, 0);
    ahb(0, 32'(`ADDR_STATUS), 0, rd);
    chk("cut status", rd, 32'h4);
  endtask
  task automatic causes;
    logic [15:0] rx;
    restartCauseIn <= 2'h2;
    restartCauseSet <= 1'b1;
    fallbackCauseIn <= 3'h3;
    fallbackCauseSet <= 1'b1;
    @(posedge clk);
    restartCauseSet <= 1'b0;
    fallbackCauseSet <= 1'b0;
    @(posedge clk);
    host.xfer({10'h000, `SEL_FALLBACK, `MODE_READONLY}, rx);
    chk("causes", rx[10:6], 5'h0E);
    host.xfer({10'h000, `SEL_FALLBACK, `MODE_READONLY}, rx);
    chk("restart cause", rx[10:6], 5'h0C);
    host.xfer({10'h001, `SEL_CHIPCFG, `MODE_NORMAL}, rx);
    chk("write data", {regWrSel_ff, regWrData_ff}, {`SEL_CHIPCFG, 10'h001});
    chk("mode request", modeReq_ff, `MODE_NORMAL);
    host.xfer({10'h000, `SEL_FALLBACK, `MODE_READONLY}, rx);
    chk("fallback cause", rx[10:6], 5'h00);
  endtask
  initial begin
    {sys_rst, hsel, hwrite, restartByHost, hwConfigOdd, restartCauseSet, fallbackCauseSet} = 7'h40;
    {haddr, hwdata, htrans, restartCauseIn, fallbackCauseIn, wakeEvents, wakeLive} = 0;
    hsize = 3'h2;
    chipMode = `MODE_INIT;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    firstFrames;
    wakeRead;
    readOnly;
    causes;
    end_of_test;
  end
  initial begin
    #1000000;
    bad_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
